// ---- rtl/pmc_pkg.sv ----
// Package for the panel meter compare logic: types and constants.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package pmc_pkg;

  localparam int unsigned VAL_W        = 24;
  localparam int unsigned AVG_DEPTH    = 8;
  localparam int unsigned CLK_MHZ      = 50;
  // Startup compensation time, tenths of a second
  localparam int unsigned STARTUP_DS_W = 8;
  localparam longint unsigned CYC_PER_DS = 64'(CLK_MHZ) * 64'd100000;
  localparam int unsigned STARTUP_CNT_W = 36;

  // Averaging setting codes
  typedef enum logic [1:0] {
    PMC_AVG_OFF = 2'b00,
    PMC_AVG_2   = 2'b01,
    PMC_AVG_4   = 2'b10,
    PMC_AVG_8   = 2'b11
  } pmc_avg_t;

  // Output type codes
  typedef enum logic [1:0] {
    PMC_TYPE_UPPER = 2'b00,
    PMC_TYPE_LOWER = 2'b01,
    PMC_TYPE_BOTH  = 2'b10
  } pmc_otype_t;

  // Display colour codes
  typedef enum logic [1:0] {
    PMC_COL_GREEN    = 2'b00,
    PMC_COL_RED      = 2'b01,
    PMC_COL_GRN_TO_RED = 2'b10,
    PMC_COL_RED_TO_GRN = 2'b11
  } pmc_colour_t;

  // Startup sequence states
  typedef enum logic [1:0] {
    PMC_ST_WAIT = 2'b00,
    PMC_ST_RUN  = 2'b01
  } pmc_state_t;

  // Scaling: disp = ((raw - in_lo) * gain_num >>> shift) + disp_lo
  typedef struct packed {
    logic signed [VAL_W-1:0] in_lo;
    logic signed [15:0]      gain_num;
    logic [4:0]              shift;
    logic signed [VAL_W-1:0] disp_lo;
  } pmc_scale_t;

  // One comparator channel
  typedef struct packed {
    pmc_otype_t              otype;
    logic signed [VAL_W-1:0] upper_sv;
    logic signed [VAL_W-1:0] lower_sv;
    logic [VAL_W-1:0]        hyst;
  } pmc_cmp_cfg_t;

  localparam logic [VAL_W-1:0] ZERO_VAL = 24'h000000;
  localparam logic [STARTUP_CNT_W-1:0] CNT_ZERO = 36'h000000000;

endpackage

// ---- rtl/pmc_avg.sv ----
// Moving average over the last 1, 2, 4 or 8 samples.
// Assumes sample_vld is a one-cycle strobe on mclk.
`timescale 1ns/1ps
module pmc_avg #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // Setting
  input  wire logic [1:0]          avg_sel,
  // Samples
  input  wire logic                sample_vld,
  input  wire logic signed [W-1:0] sample,
  // Result
  output logic                     mean_vld,
  output logic signed [W-1:0]      mean
);

  logic signed [W-1:0] hist_r [DEPTH];
  logic signed [W+3:0] sum;
  logic signed [W+3:0] shifted;

  // ****************
  // Sample history
  // ****************
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_r[i] <= '0;
      end
    end else if (sample_vld) begin
      hist_r[0] <= sample;
      for (int i = 1; i < DEPTH; i++) begin
        hist_r[i] <= hist_r[i-1];
      end
    end
  end

  // ****************
  // Mean of newest N
  // ****************
  // mean of recent N
  always_comb begin
    sum = (W+4)'(sample);
    for (int i = 1; i < DEPTH; i++) begin
      if (i < (1 << avg_sel)) begin
        sum = sum + (W+4)'(hist_r[i-1]);
      end
    end
  end

  assign shifted = sum >>> avg_sel;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mean     <= '0;
      mean_vld <= 1'b0;
    end else begin
      mean_vld <= sample_vld;
      if (sample_vld) begin
        // Mean counts the arriving sample as the newest
        mean <= shifted[W-1:0];
      end
    end
  end

endmodule

// ---- rtl/pmc_cmp.sv ----
// One comparator channel with output type and hysteresis.
// Assumes the value input is already scaled and zero-shifted; hold acts through eval.
`timescale 1ns/1ps
module pmc_cmp #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // Control
  input  wire logic                force_off,
  input  wire logic                eval,
  input  wire pmc_pkg::pmc_cmp_cfg_t cfg,
  input  wire logic signed [W-1:0] value,
  // Result
  output logic                     out_r
);

  logic signed [W+1:0] v;
  logic signed [W+1:0] up;
  logic signed [W+1:0] lo;
  logic signed [W+1:0] hy;
  logic                hi_on;
  logic                hi_hold;
  logic                lo_on;
  logic                lo_hold;
  logic                on_cond;
  logic                hold_cond;
  logic                out_nxt;

  assign v  = (W+2)'(value);
  assign up = (W+2)'(cfg.upper_sv);
  assign lo = (W+2)'(cfg.lower_sv);
  assign hy = (W+2)'({1'b0, cfg.hyst});

  assign hi_on   = v >= up;
  assign hi_hold = v > up - hy;
  assign lo_on   = v <= lo;
  assign lo_hold = v < lo + hy;

  assign on_cond = (cfg.otype == pmc_pkg::PMC_TYPE_UPPER) ? hi_on :
                   (cfg.otype == pmc_pkg::PMC_TYPE_LOWER) ? lo_on :
                   (hi_on | lo_on);
  assign hold_cond = (cfg.otype == pmc_pkg::PMC_TYPE_UPPER) ? hi_hold :
                     (cfg.otype == pmc_pkg::PMC_TYPE_LOWER) ? lo_hold :
                     (hi_hold | lo_hold);

  assign out_nxt = force_off ? 1'b0 :
                   !eval     ? out_r :
                   out_r     ? hold_cond : on_cond;

  always_ff @(posedge mclk) begin
    if (srst) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

endmodule

// ---- rtl/pmc_top.sv ----
// Top of the panel meter compare logic: scaling, averaging, zero shift,
// hold, teaching, startup suppression, two comparators and colour.
// Assumes all inputs synchronous to mclk; key inputs are one-cycle presses.
`timescale 1ns/1ps
module pmc_top #(
  parameter int unsigned W = pmc_pkg::VAL_W
) (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            srst,
  // Input samples
  input  wire logic                            sample_vld,
  input  wire logic signed [W-1:0]             raw_sample,
  input  wire logic                            pulse_input_sel,
  // Configuration
  input  wire logic [1:0]                      avg_sel,
  input  wire pmc_pkg::pmc_scale_t             scale_cfg,
  input  wire pmc_pkg::pmc_cmp_cfg_t           cmp1_cfg,
  input  wire pmc_pkg::pmc_cmp_cfg_t           cmp2_cfg,
  input  wire logic [1:0]                      colour_sel,
  input  wire logic [pmc_pkg::STARTUP_DS_W-1:0] startup_ds,
  // Protection
  input  wire logic                            key_protect,
  input  wire logic                            zero_protect,
  // Keys and events
  input  wire logic                            up_zero_key,
  input  wire logic                            level_key,
  input  wire logic                            measure_shown,
  input  wire logic                            hold_in,
  input  wire logic                            mode_change,
  input  wire logic                            settings_init,
  // Teaching
  input  wire logic                            teach_req,
  input  wire logic [1:0]                      teach_target,
  // Results
  output logic signed [W-1:0]                  disp_value,
  output logic signed [W-1:0]                  zero_offset,
  output logic                                 zero_active,
  output logic signed [W-1:0]                  teach_value,
  output logic                                 teach_vld,
  output logic [1:0]                           teach_dst,
  output logic                                 level_step,
  output logic                                 first_compare_output,
  output logic                                 second_compare_output,
  output logic                                 first_ind,
  output logic                                 second_ind,
  output logic                                 colour_red,
  output logic                                 startup_done
);

  // ****************
  // Decode helpers
  // ****************
  // Key action allowed only while keys unprotected
  function automatic logic key_gate(input logic key, input logic prot);
    return key & !prot;
  endfunction

  // Red when fixed red, or per comparison result
  function automatic logic colour_is_red(input logic [1:0] sel, input logic hit);
    logic red;
    case (sel)
      pmc_pkg::PMC_COL_RED:        red = 1'b1;
      pmc_pkg::PMC_COL_GRN_TO_RED: red = hit;
      pmc_pkg::PMC_COL_RED_TO_GRN: red = !hit;
      default:                     red = 1'b0;
    endcase
    return red;
  endfunction

  // ****************
  // Scaling
  // ****************
  logic signed [W:0]    diff;
  logic signed [W+16:0] prod;
  logic signed [W+16:0] prod_sh;
  logic signed [W-1:0]  scaled_r;
  logic                 scaled_vld_r;

  assign diff    = (W+1)'(raw_sample) - (W+1)'(scale_cfg.in_lo);
  assign prod    = (W+17)'(diff) * (W+17)'(scale_cfg.gain_num);
  assign prod_sh = prod >>> scale_cfg.shift;

  // Result wraps to W bits; settings keep display in range
  always_ff @(posedge mclk) begin
    if (srst) begin
      scaled_r     <= '0;
      scaled_vld_r <= 1'b0;
    end else begin
      scaled_vld_r <= sample_vld;
      if (sample_vld) begin
        scaled_r <= prod_sh[W-1:0] + scale_cfg.disp_lo;
      end
    end
  end

  // ****************
  // Averaging
  // ****************
  logic                mean_vld;
  logic signed [W-1:0] mean;

  // History keeps shifting while averaging is off
  // selectable averaging
  pmc_avg #(
    .W     (W),
    .DEPTH (pmc_pkg::AVG_DEPTH)
  ) u_avg (
    .mclk       (mclk),
    .srst       (srst),
    .avg_sel    (avg_sel),
    .sample_vld (scaled_vld_r),
    .sample     (scaled_r),
    .mean_vld   (mean_vld),
    .mean       (mean)
  );

  // ****************
  // Forced zero
  // ****************
  logic signed [W-1:0] meas_r;
  logic signed [W-1:0] zero_off_nxt;
  logic                zero_act_nxt;
  logic                zero_press;

  assign zero_press   = key_gate(up_zero_key, key_protect) & measure_shown & !zero_protect;
  assign zero_act_nxt = zero_press ? !zero_active : zero_active;
  assign zero_off_nxt = !zero_press ? zero_offset :
                        zero_active ? '0 : mean;

  // Settings init also drops any zero shift
  always_ff @(posedge mclk) begin
    if (srst || settings_init) begin
      zero_offset <= '0;
      zero_active <= 1'b0;
    end else begin
      zero_offset <= zero_off_nxt;
      zero_active <= zero_act_nxt;
    end
  end

  // ****************
  // Hold
  // ****************
  logic signed [W-1:0] shifted_val;
  logic                fresh;

  // Zero offset and compare use the unfrozen mean
  assign shifted_val = mean - zero_offset;
  assign fresh       = mean_vld & !hold_in;

  always_ff @(posedge mclk) begin
    if (srst) begin
      meas_r <= '0;
    end else if (fresh) begin
      meas_r <= shifted_val;
    end
  end

  assign disp_value = meas_r;

  // ****************
  // Teaching
  // ****************
  logic teach_ok;

  // Captured value is the held display value
  assign teach_ok = key_gate(teach_req, key_protect);

  always_ff @(posedge mclk) begin
    if (srst) begin
      teach_value <= '0;
      teach_vld   <= 1'b0;
      teach_dst   <= 2'b00;
    end else begin
      teach_vld <= teach_ok;
      if (teach_ok) begin
        teach_value <= meas_r;
        teach_dst   <= teach_target;
      end
    end
  end

  assign level_step = key_gate(level_key, key_protect);

  // ****************
  // Startup compensation
  // ****************
  pmc_pkg::pmc_state_t             st_r;
  pmc_pkg::pmc_state_t             st_nxt;
  logic [pmc_pkg::STARTUP_CNT_W-1:0] cnt_r;
  logic [pmc_pkg::STARTUP_CNT_W-1:0] limit;
  logic                             cnt_end;

  assign limit   = pmc_pkg::STARTUP_CNT_W'(64'(startup_ds) * pmc_pkg::CYC_PER_DS);
  assign cnt_end = cnt_r >= limit;

  // Non-pulse input leaves the wait on the first edge
  // suppress until time elapsed
  always_comb begin
    case (st_r)
      pmc_pkg::PMC_ST_WAIT: st_nxt = (cnt_end || !pulse_input_sel) ?
                                     pmc_pkg::PMC_ST_RUN : pmc_pkg::PMC_ST_WAIT;
      pmc_pkg::PMC_ST_RUN:  st_nxt = pmc_pkg::PMC_ST_RUN;
      default:              st_nxt = pmc_pkg::PMC_ST_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r  <= pmc_pkg::PMC_ST_WAIT;
      cnt_r <= pmc_pkg::CNT_ZERO;
    end else begin
      st_r  <= st_nxt;
      if (st_r == pmc_pkg::PMC_ST_WAIT) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign startup_done = (st_r == pmc_pkg::PMC_ST_RUN);

  // ****************
  // Comparators
  // ****************
  logic force_off;
  logic eval;

  assign force_off = mode_change | settings_init | !startup_done;
  assign eval      = mean_vld & !hold_in;

  // Both channels see the same zero-shifted value and gated strobe
  // two independent channels
  pmc_cmp #(
    .W (W)
  ) u_cmp1 (
    .mclk      (mclk),
    .srst      (srst),
    .force_off (force_off),
    .eval      (eval),
    .cfg       (cmp1_cfg),
    .value     (shifted_val),
    .out_r     (first_compare_output)
  );

  pmc_cmp #(
    .W (W)
  ) u_cmp2 (
    .mclk      (mclk),
    .srst      (srst),
    .force_off (force_off),
    .eval      (eval),
    .cfg       (cmp2_cfg),
    .value     (shifted_val),
    .out_r     (second_compare_output)
  );

  // Indicators follow the outputs directly
  assign first_ind  = first_compare_output;
  assign second_ind = second_compare_output;

  // ****************
  // Display colour
  // ****************
  logic any_on;
  logic red_nxt;

  assign any_on = first_compare_output | second_compare_output;
  assign red_nxt = colour_is_red(colour_sel, any_on);

  always_ff @(posedge mclk) begin
    if (srst) begin
      colour_red <= 1'b0;
    end else begin
      colour_red <= red_nxt;
    end
  end

endmodule

// ---- sim/pmc_top_checker.sv ----
// Port checker for pmc_top, attached by bind.
// Assumes one clock mclk and synchronous active-high srst.
`timescale 1ns/1ps
module pmc_top_checker #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                srst,
  // Watched inputs
  input wire logic                mode_change,
  input wire logic                settings_init,
  input wire logic                key_protect,
  input wire logic                zero_protect,
  input wire logic                hold_in,
  input wire logic [1:0]          colour_sel,
  // Watched outputs
  input wire logic                level_step,
  input wire logic                zero_active,
  input wire logic signed [W-1:0] disp_value,
  input wire logic                first_compare_output,
  input wire logic                second_compare_output,
  input wire logic                first_ind,
  input wire logic                second_ind,
  input wire logic                colour_red,
  input wire logic                startup_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ********
  // Assertions
  // ********
  chk_ind_one: assert property (first_ind == first_compare_output)
    else $error("first indicator differs from output");
  chk_ind_two: assert property (second_ind == second_compare_output)
    else $error("second indicator differs from output");
  chk_mode_off: assert property (mode_change |=> !first_compare_output && !second_compare_output)
    else $error("output on after mode change");
  chk_init_off: assert property (settings_init |=> !(first_compare_output || second_compare_output))
    else $error("output on after settings init");
  chk_startup_gate: assert property (!startup_done |=> !first_compare_output && !second_compare_output)
    else $error("output on before startup done");
  chk_level_block: assert property (key_protect |-> !level_step)
    else $error("level step while keys protected");
  chk_zero_guard: assert property ((zero_protect || key_protect) && !zero_active |=> !zero_active)
    else $error("zero shift set while protected");
  chk_colour_fixed: assert property (!colour_sel[1] |=> colour_red == $past(colour_sel[0]))
    else $error("fixed colour wrong");
  chk_hold_freeze: assert property (hold_in[*5] |-> $stable(disp_value))
    else $error("value moved during hold");
  cover property (first_compare_output && second_compare_output);
  cover property ($rose(zero_active));
  cover property (hold_in[*5]);
  cover property ($rose(startup_done));
endmodule

bind pmc_top pmc_top_checker #(.W(W)) u_chk (.mclk, .srst, .mode_change, .settings_init,
  .key_protect, .zero_protect, .hold_in, .colour_sel, .level_step, .zero_active, .disp_value,
  .first_compare_output, .second_compare_output, .first_ind, .second_ind, .colour_red,
  .startup_done);

// ---- sim/pmc_top_tb_top.sv ----
// Self-checking bench for pmc_top against an integer model.
// Assumes the rtl files and the checker are compiled first.
`timescale 1ns/1ps
module pmc_top_tb_top;
  // ********
  // Signals and model state
  // ********
  logic mclk = 1'b0, srst = 1'b1, sample_vld = 1'b0, pulse_input_sel = 1'b1;
  logic signed [23:0] raw_sample = 24'h000000;
  logic [1:0] avg_sel = 2'h0, colour_sel = 2'h0, teach_target = 2'h0, teach_dst;
  pmc_pkg::pmc_scale_t scale_cfg = '{24'h0, 16'h0001, 5'h00, 24'h0};
  pmc_pkg::pmc_cmp_cfg_t cmp1_cfg = '{pmc_pkg::PMC_TYPE_UPPER, 24'h64, 24'h0, 24'ha};
  pmc_pkg::pmc_cmp_cfg_t cmp2_cfg = '0;
  logic [7:0] startup_ds = 8'h01;
  logic key_protect = 1'b0, zero_protect = 1'b1, up_zero_key = 1'b0, level_key = 1'b0;
  logic measure_shown = 1'b1, hold_in = 1'b0, mode_change = 1'b0, settings_init = 1'b0;
  logic teach_req = 1'b0;
  logic signed [23:0] disp_value, zero_offset, teach_value;
  logic zero_active, teach_vld, level_step, first_compare_output, second_compare_output;
  logic first_ind, second_ind, colour_red, startup_done;
  int errors = 0, compares = 0, seed = 96707, o1, o2, zoff, mdisp, i, v;
  int hist[$];
  int sq[9] = '{60, 100, 97, 94, 30, 20, 23, 25, 60};

  always #10 mclk = ~mclk;

  pmc_top uut (.mclk, .srst, .sample_vld, .raw_sample, .pulse_input_sel, .avg_sel, .scale_cfg,
    .cmp1_cfg, .cmp2_cfg, .colour_sel, .startup_ds, .key_protect, .zero_protect, .up_zero_key,
    .level_key, .measure_shown, .hold_in, .mode_change, .settings_init, .teach_req,
    .teach_target, .disp_value, .zero_offset, .zero_active, .teach_value, .teach_vld,
    .teach_dst, .level_step, .first_compare_output, .second_compare_output, .first_ind,
    .second_ind, .colour_red, .startup_done);

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic int cmp_next(int st, int x, pmc_pkg::pmc_cmp_cfg_t c);
    int up, lo, h;
    up = int'(c.upper_sv);
    lo = int'(c.lower_sv);
    h = int'(c.hyst);
    case (c.otype)
      pmc_pkg::PMC_TYPE_UPPER: return st ? int'(x > up - h) : int'(x >= up);
      pmc_pkg::PMC_TYPE_LOWER: return st ? int'(x < lo + h) : int'(x <= lo);
      default: return st ? int'(x > up - h || x < lo + h) : int'(x >= up || x <= lo);
    endcase
  endfunction

  task automatic do_reset();
    srst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    hist = '{0, 0, 0, 0, 0, 0, 0, 0};
    {o1, o2, zoff, mdisp} = '0;
  endtask

  // Sample in, model update, compare after the colour stage settles
  task automatic send(input int raw, input bit check = 1'b1);
    int n, s;
    logic r;
    sample_vld = 1'b1;
    raw_sample = raw[23:0];
    @(posedge mclk);
    #1 sample_vld = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    s = ((raw - int'(scale_cfg.in_lo)) * int'(scale_cfg.gain_num)) >>> scale_cfg.shift;
    void'(hist.pop_back());
    hist.push_front(s + int'(scale_cfg.disp_lo));
    n = 1 << avg_sel;
    s = 0;
    for (int k = 0; k < n; k++) s += hist[k];
    if (!hold_in) begin
      mdisp = (s >>> avg_sel) - zoff;
      o1 = cmp_next(o1, mdisp, cmp1_cfg);
      o2 = cmp_next(o2, mdisp, cmp2_cfg);
    end
    r = colour_sel[1] ? colour_sel[0] ^ (o1 != 0 || o2 != 0) : colour_sel[0];
    if (check) begin
      chk(disp_value, mdisp[23:0], "disp");
      chk(24'(first_compare_output), 24'(o1[0]), "first_compare_output");
      chk(24'(second_compare_output), 24'(o2[0]), "second_compare_output");
      chk(24'({first_ind, second_ind}), 24'({o1[0], o2[0]}), "ind");
      chk(24'(colour_red), 24'(r), "colour");
    end
  endtask

  // Settings init when j is 0, mode change otherwise
  task automatic force_off(input int j);
    settings_init = (j == 0);
    mode_change = (j != 0);
    @(posedge mclk);
    #1 {settings_init, mode_change} = 2'h0;
    {o1, o2} = '0;
    chk(24'({first_compare_output, second_compare_output}), 24'h0, "forced");
  endtask

  task automatic zpress();
    up_zero_key = 1'b1;
    @(posedge mclk);
    #1 up_zero_key = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // ********
  // Sequence and watchdog
  // ********
  initial begin
    do_reset();
    send(200, 1'b0);
    chk(24'({first_compare_output, startup_done}), 24'h0, "suppress");
    pulse_input_sel = 1'b0;
    do_reset();
    @(posedge mclk);
    #1 chk(24'(startup_done), 24'h1, "startup");
    scale_cfg = '{24'h00000a, 16'hfffe, 5'h01, 24'h000064};
    send(30);
    send(-40);
    send(200);
    $display("test scaling done");
    scale_cfg = '{24'h0, 16'h0001, 5'h00, 24'h0};
    for (i = 0; i < 4; i++) begin
      avg_sel = i[1:0];
      for (v = 1; v < 9; v++) send(8 * v + 16 * i);
    end
    avg_sel = 2'h0;
    $display("test averaging done");
    for (i = 0; i < 2; i++) begin
      send(112);
      force_off(i);
    end
    cmp1_cfg = '{pmc_pkg::PMC_TYPE_BOTH, 24'h64, 24'h14, 24'h5};
    cmp2_cfg = '{pmc_pkg::PMC_TYPE_UPPER, 24'h32, 24'h0, 24'ha};
    for (i = 0; i < 9; i++) begin
      colour_sel = i[1:0];
      send(sq[i]);
    end
    force_off(0);
    cmp1_cfg = '{pmc_pkg::PMC_TYPE_UPPER, 24'h64, 24'h0, 24'ha};
    cmp2_cfg = '{pmc_pkg::PMC_TYPE_LOWER, 24'h0, 24'h28, 24'h8};
    for (i = 0; i < 40; i++) begin
      colour_sel = 2'($random(seed));
      send(($random(seed) & 32'hff) % 160);
    end
    $display("test compare done");
    force_off(1);
    cmp1_cfg = '{pmc_pkg::PMC_TYPE_UPPER, 24'h7fffff, 24'h0, 24'h0};
    cmp2_cfg = '{pmc_pkg::PMC_TYPE_LOWER, 24'h0, 24'h800000, 24'h0};
    send(50);
    zpress();
    chk(24'(zero_active), 24'h0, "zero prot");
    zero_protect = 1'b0;
    key_protect = 1'b1;
    zpress();
    chk(24'(zero_active), 24'h0, "zero keyprot");
    key_protect = 1'b0;
    measure_shown = 1'b0;
    zpress();
    chk(24'(zero_active), 24'h0, "zero hidden");
    measure_shown = 1'b1;
    zpress();
    chk(24'(zero_active), 24'h1, "zero on");
    chk(zero_offset, 24'h000032, "zero offset");
    zoff = 50;
    send(70);
    zpress();
    chk(24'(zero_active), 24'h0, "zero off");
    zoff = 0;
    send(70);
    hold_in = 1'b1;
    send(999);
    hold_in = 1'b0;
    send(10);
    $display("test zero and hold done");
    for (i = 0; i < 5; i++) begin
      teach_target = i[1:0];
      key_protect = (i == 4);
      teach_req = 1'b1;
      @(posedge mclk);
      #1 teach_req = 1'b0;
      for (v = 0; v < 4 && teach_vld !== 1'b1; v++) @(posedge mclk) #1;
      chk(24'(teach_vld), 24'(i < 4), "teach vld");
      if (i < 4) chk(teach_value, mdisp[23:0], "teach value");
      if (i < 4) chk(24'(teach_dst), 24'(i), "teach dst");
      @(posedge mclk);
      #1;
    end
    key_protect = 1'b0;
    level_key = 1'b1;
    #1 chk(24'(level_step), 24'h1, "level");
    @(posedge mclk);
    #1 key_protect = 1'b1;
    #1 chk(24'(level_step), 24'h0, "level prot");
    @(posedge mclk);
    #1 {level_key, key_protect} = 2'h0;
    $display("test teach and level done");
    final_report();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule
